// ==== csr_pkg.sv ====
package csr_pkg;
   localparam logic [7:0] SLAVE_ADDR    = 8'hD2;
   localparam int         CMD_BYTE_BIT  = 7;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;
   localparam logic [6:0] IDX_FREQ      = 7'h00;
   localparam logic [6:0] IDX_HOST      = 7'h01;
   localparam logic [6:0] IDX_PCI       = 7'h02;
   localparam logic [7:0] NUM_BYTES     = 8'h03;
   localparam logic [7:0] B0_MASK       = 8'hFE;
   localparam logic [7:0] B0_RST        = 8'h00;
   localparam logic [2:0] HOST_EN_RST   = 3'h7;
   localparam logic [6:0] PCI_EN_RST    = 7'h7F;
   localparam int         SEL_LO_MSB    = 7;
   localparam int         SEL_LO_LSB    = 4;
   localparam int         OVR_BIT       = 3;
   localparam int         SEL_TOP_BIT   = 2;
   localparam int         SPREAD_BIT    = 1;
   localparam int         HOST_EN_MSB   = 7;
   localparam int         HOST_EN_LSB   = 5;
   localparam int         PCI_EN_MSB    = 6;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_CMD       = 9'h008,
      ST_CMD_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RDATA_ACK = 9'h100
   } csr_state_t;

   function automatic logic [4:0] csr_sw_sel(input logic [7:0] b0);
      csr_sw_sel = {b0[SEL_TOP_BIT], b0[SEL_LO_MSB:SEL_LO_LSB]};
   endfunction
endpackage

// ==== csr_regs.sv ====
`timescale 1ns/1ps
module csr_regs
   import csr_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset,
   input  wire logic [4:0] i_strap_freq_pins,
   input  wire logic       i_wr_en,
   input  wire logic [6:0] i_wr_index,
   input  wire logic [7:0] i_wr_data,
   input  wire logic [6:0] i_rd_index,
   output logic      [7:0] o_rd_data,
   output logic      [4:0] o_sw_freq_sel,
   output logic            o_strap_override_bit,
   output logic            o_spread_enable,
   output logic      [2:0] o_host_clk_pair_en,
   output logic      [6:0] o_bus_clk_out_en,
   output logic      [4:0] o_freq_sel_eff
);
   typedef struct packed {
      logic [7:0] b0;
      logic [2:0] host_en;
      logic [6:0] pci_en;
      logic [4:0] strap;
      logic       strap_taken;
      logic [7:0] rd_data;
      logic [4:0] freq_eff;
   } csr_regs_state_t;

   csr_regs_state_t r;
   csr_regs_state_t next_r;

   function automatic logic [7:0] rd_byte(input csr_regs_state_t s, input logic [6:0] idx);
      case (idx)
         IDX_FREQ: rd_byte = s.b0 & B0_MASK;
         IDX_HOST: rd_byte = {s.host_en, s.strap};
         IDX_PCI:  rd_byte = {1'b0, s.pci_en};
         default:  rd_byte = 8'h00;
      endcase
   endfunction

   always_comb begin
      next_r = r;
      // Straps are caught on the first edge after reset release
      if (!r.strap_taken) begin
         next_r.strap       = i_strap_freq_pins;
         next_r.strap_taken = 1'b1;
      end
      if (i_wr_en) begin
         case (i_wr_index)
            IDX_FREQ: next_r.b0 = i_wr_data & B0_MASK;
            IDX_HOST: next_r.host_en = i_wr_data[HOST_EN_MSB:HOST_EN_LSB];
            IDX_PCI:  next_r.pci_en = i_wr_data[PCI_EN_MSB:0];
            default:  next_r.pci_en = r.pci_en;
         endcase
      end
      next_r.rd_data  = rd_byte(r, i_rd_index);
      next_r.freq_eff = r.b0[OVR_BIT] ? csr_sw_sel(r.b0) : r.strap;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         r <= '{b0: B0_RST, host_en: HOST_EN_RST, pci_en: PCI_EN_RST, strap: 5'h00,
                strap_taken: 1'b0, rd_data: 8'h00, freq_eff: 5'h00};
      end else begin
         r <= next_r;
      end
   end

   assign o_rd_data            = r.rd_data;
   assign o_sw_freq_sel        = csr_sw_sel(r.b0);
   assign o_strap_override_bit = r.b0[OVR_BIT];
   assign o_spread_enable      = r.b0[SPREAD_BIT];
   assign o_host_clk_pair_en   = r.host_en;
   assign o_bus_clk_out_en     = r.pci_en;
   assign o_freq_sel_eff       = r.freq_eff;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   eff_freq_mux_a: assert property (
      ##1 o_freq_sel_eff == ($past(r.b0[OVR_BIT]) ? $past(csr_sw_sel(r.b0)) : $past(r.strap)))
      else $error("effective frequency select wrong");
   reserved_zero_a: assert property (
      ((i_rd_index == IDX_FREQ) |=> (o_rd_data[0] == 1'b0)) and
      ((i_rd_index == IDX_PCI) |=> (o_rd_data[7] == 1'b0)))
      else $error("reserved bit read nonzero");
   strap_hold_a: assert property (
      r.strap_taken && i_wr_en |=> r.strap == $past(r.strap))
      else $error("latched strap changed by write");
endmodule

// ==== csr_smbus.sv ====
`timescale 1ns/1ps
module csr_smbus
   import csr_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   input  wire logic [4:0] i_strap_freq_pins,
   output logic      [4:0] o_sw_freq_sel,
   output logic            o_strap_override_bit,
   output logic            o_spread_enable,
   output logic      [2:0] o_host_clk_pair_en,
   output logic      [6:0] o_bus_clk_out_en,
   output logic      [4:0] o_freq_sel_eff
);
   typedef struct packed {
      csr_state_t st;
      logic       scl_q;
      logic       sda_q;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic       rw;
      logic       block;
      logic       count_pend;
      logic [6:0] index;
      logic       sda_oe;
      logic       wr_en;
      logic [6:0] wr_index;
      logic [7:0] wr_data;
   } csr_smbus_state_t;

   csr_smbus_state_t r;
   csr_smbus_state_t next_r;
   logic [7:0]       rd_data;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_cond;
   logic             stop_cond;
   logic             rx_state;
   logic             rx_done;
   logic [7:0]       tx_byte;

   csr_regs u_regs (
      .i_sys_clk            (i_sys_clk),
      .i_reset              (i_reset),
      .i_strap_freq_pins    (i_strap_freq_pins),
      .i_wr_en              (r.wr_en),
      .i_wr_index           (r.wr_index),
      .i_wr_data            (r.wr_data),
      .i_rd_index           (r.index),
      .o_rd_data            (rd_data),
      .o_sw_freq_sel        (o_sw_freq_sel),
      .o_strap_override_bit (o_strap_override_bit),
      .o_spread_enable      (o_spread_enable),
      .o_host_clk_pair_en   (o_host_clk_pair_en),
      .o_bus_clk_out_en     (o_bus_clk_out_en),
      .o_freq_sel_eff       (o_freq_sel_eff)
   );

   assign scl_rise   = i_scl & ~r.scl_q;
   assign scl_fall   = ~i_scl & r.scl_q;
   assign start_cond = i_scl & r.scl_q & r.sda_q & ~i_sda;
   assign stop_cond  = i_scl & r.scl_q & ~r.sda_q & i_sda;
   assign rx_state   = (r.st == ST_ADDR) || (r.st == ST_CMD) || (r.st == ST_WDATA);
   assign rx_done    = rx_state && scl_fall && (r.bitcnt == BYTE_BITS);
   // A block read starts with the byte count, then data from index 0
   assign tx_byte    = r.count_pend ? NUM_BYTES : rd_data;

   always_comb begin
      next_r       = r;
      next_r.scl_q = i_scl;
      next_r.sda_q = i_sda;
      next_r.wr_en = 1'b0;
      if (start_cond) begin
         next_r.st     = ST_ADDR;
         next_r.bitcnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop_cond) begin
         next_r.st     = ST_IDLE;
         next_r.sda_oe = 1'b0;
      end else begin
         if (rx_state && scl_rise && r.bitcnt != BYTE_BITS) begin
            next_r.shreg  = {r.shreg[6:0], i_sda};
            next_r.bitcnt = r.bitcnt + 4'h1;
         end
         case (r.st)
            ST_ADDR: begin
               if (rx_done) begin
                  next_r.bitcnt = 4'h0;
                  if (r.shreg[7:1] == SLAVE_ADDR[7:1]) begin
                     next_r.rw     = r.shreg[0];
                     next_r.sda_oe = 1'b1;
                     next_r.st     = ST_ADDR_ACK;
                  end else begin
                     next_r.st = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (r.rw) begin
                     next_r.st     = ST_RDATA;
                     next_r.shreg  = tx_byte;
                     next_r.sda_oe = ~tx_byte[7];
                  end else begin
                     next_r.st     = ST_CMD;
                     next_r.sda_oe = 1'b0;
                  end
               end
            end
            ST_CMD: begin
               if (rx_done) begin
                  next_r.bitcnt     = 4'h0;
                  next_r.block      = ~r.shreg[CMD_BYTE_BIT];
                  next_r.count_pend = ~r.shreg[CMD_BYTE_BIT];
                  next_r.index      = r.shreg[CMD_BYTE_BIT] ? r.shreg[6:0] : 7'h00;
                  next_r.sda_oe     = 1'b1;
                  next_r.st         = ST_CMD_ACK;
               end
            end
            ST_CMD_ACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.st     = ST_WDATA;
               end
            end
            ST_WDATA: begin
               if (rx_done) begin
                  next_r.bitcnt = 4'h0;
                  if (r.count_pend) begin
                     next_r.count_pend = 1'b0;
                  end else begin
                     next_r.wr_en    = 1'b1;
                     next_r.wr_index = r.index;
                     next_r.wr_data  = r.shreg;
                     if (r.block) begin
                        next_r.index = r.index + 7'h01;
                     end
                  end
                  next_r.sda_oe = 1'b1;
                  next_r.st     = ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.st     = r.block ? ST_WDATA : ST_IDLE;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (r.bitcnt == LAST_TX_BIT) begin
                     next_r.sda_oe = 1'b0;
                     next_r.st     = ST_RDATA_ACK;
                  end else begin
                     next_r.shreg  = {r.shreg[6:0], 1'b0};
                     next_r.sda_oe = ~r.shreg[6];
                     next_r.bitcnt = r.bitcnt + 4'h1;
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (scl_rise) begin
                  if (i_sda) begin
                     next_r.st = ST_IDLE;
                  end else if (r.count_pend) begin
                     next_r.count_pend = 1'b0;
                  end else if (r.block) begin
                     next_r.index = r.index + 7'h01;
                  end
               end else if (scl_fall) begin
                  next_r.st     = ST_RDATA;
                  next_r.shreg  = tx_byte;
                  next_r.sda_oe = ~tx_byte[7];
                  next_r.bitcnt = 4'h0;
               end
            end
            default: next_r.st = r.st;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         r <= '{st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, bitcnt: 4'h0, shreg: 8'h00, rw: 1'b0,
                block: 1'b0, count_pend: 1'b0, index: 7'h00, sda_oe: 1'b0, wr_en: 1'b0,
                wr_index: 7'h00, wr_data: 8'h00};
      end else begin
         r <= next_r;
      end
   end

   assign o_sda    = 1'b0;
   assign o_sda_oe = r.sda_oe;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   sequence s_addr_done;
      !start_cond && !stop_cond && r.st == ST_ADDR && rx_done;
   endsequence
   sequence s_cmd_done;
      !start_cond && !stop_cond && r.st == ST_CMD && rx_done;
   endsequence

   addr_match_ack_a: assert property (
      s_addr_done and (r.shreg[7:1] == SLAVE_ADDR[7:1]) |=> r.sda_oe && r.st == ST_ADDR_ACK)
      else $error("own address not acknowledged");
   addr_other_ignore_a: assert property (
      s_addr_done and (r.shreg[7:1] != SLAVE_ADDR[7:1]) |=> !r.sda_oe && r.st == ST_IDLE)
      else $error("foreign address not ignored");
   cmd_byte_index_a: assert property (
      s_cmd_done and r.shreg[7] |=> r.index == $past(r.shreg[6:0]) && !r.block && r.sda_oe)
      else $error("byte command index not taken");
   cmd_block_zero_a: assert property (
      s_cmd_done and !r.shreg[7] |=> r.index == 7'h00 && r.block && r.count_pend)
      else $error("block command did not start at zero");
   write_strobe_a: assert property (
      !start_cond && !stop_cond && r.st == ST_WDATA && rx_done && !r.count_pend
      |=> r.wr_en && r.wr_data == $past(r.shreg) && r.wr_index == $past(r.index) ##1 !r.wr_en)
      else $error("data byte not written");
   read_msb_first_a: assert property (
      !start_cond && !stop_cond && r.st == ST_ADDR_ACK && scl_fall && r.rw
      |=> r.st == ST_RDATA && r.sda_oe == ~$past(tx_byte[7]))
      else $error("read byte not started with msb");
   nack_ends_read_a: assert property (
      !start_cond && !stop_cond && r.st == ST_RDATA_ACK && scl_rise && i_sda
      |=> r.st == ST_IDLE && !r.sda_oe)
      else $error("host nack did not end read");
   stop_release_a: assert property (
      stop_cond |=> (r.st == ST_IDLE && !r.sda_oe) [*2])
      else $error("stop did not release line");
endmodule

// ==== csr_host.sv ====
`timescale 1ns/1ps
module csr_host (
   input  wire logic i_sys_clk,
   input  wire logic i_sda_wire,
   output logic      o_scl,
   output logic      o_sda_rel
);
   initial begin
      o_scl = 1'b1;
      o_sda_rel = 1'b1;
   end

   task automatic clks(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   // Data moves only while the bus clock is low
   task automatic bit_io(input logic b, output logic s);
      clks(2);
      o_sda_rel = b;
      clks(2);
      o_scl = 1'b1;
      clks(2);
      s = i_sda_wire;
      clks(2);
      o_scl = 1'b0;
   endtask

   // Serves as start and as repeated start
   task automatic start();
      o_sda_rel = 1'b1;
      clks(2);
      o_scl = 1'b1;
      clks(4);
      o_sda_rel = 1'b0;
      clks(4);
      o_scl = 1'b0;
   endtask

   task automatic stop();
      clks(2);
      o_sda_rel = 1'b0;
      clks(2);
      o_scl = 1'b1;
      clks(4);
      o_sda_rel = 1'b1;
      clks(4);
   endtask

   // Address, command and data bytes go MSB first; ack 0 means acknowledged
   task automatic send8(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, ack);
   endtask

   task automatic recv8(output logic [7:0] b, input logic host_nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(host_nack, s);
   endtask
endmodule

// ==== clock_synth_smbus_config_regs_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %0h want %0h", $time, a, e); end end
module clock_synth_smbus_config_regs_tb
   import csr_pkg::*;
;
   logic       i_sys_clk, i_reset, scl, sda_rel, sda_wire, o_sda, o_sda_oe, ovr, spread, a0, a1, a2, a3;
   logic [4:0] strap, strap_cap, sw_sel, eff;
   logic [2:0] host_en, m_host;
   logic [6:0] bus_en, m_pci;
   logic [7:0] m0, d, cnt;
   int         miscompares, checked;

   // Open-drain wire with pull-up
   assign sda_wire = sda_rel & (o_sda_oe ? o_sda : 1'b1);

   csr_smbus DUT (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_wire), .o_sda(o_sda),
      .o_sda_oe(o_sda_oe), .i_strap_freq_pins(strap), .o_sw_freq_sel(sw_sel), .o_strap_override_bit(ovr),
      .o_spread_enable(spread), .o_host_clk_pair_en(host_en), .o_bus_clk_out_en(bus_en), .o_freq_sel_eff(eff));
   csr_host host (.i_sys_clk(i_sys_clk), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_rel(sda_rel));

   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   function automatic logic [7:0] exp_rd(input logic [6:0] idx);
      case (idx)
         IDX_FREQ: exp_rd = m0;
         IDX_HOST: exp_rd = {m_host, strap_cap};
         IDX_PCI:  exp_rd = {1'b0, m_pci};
         default:  exp_rd = 8'h00;
      endcase
   endfunction

   task automatic model_wr(input logic [6:0] idx, input logic [7:0] v);
      case (idx)
         IDX_FREQ: m0 = v & B0_MASK;
         IDX_HOST: m_host = v[7:5];
         IDX_PCI:  m_pci = v[6:0];
         default: ;
      endcase
   endtask

   task automatic chk_outs();
      `CHK(sw_sel, {m0[2], m0[7:4]})
      `CHK(ovr, m0[3])
      `CHK(eff, m0[3] ? {m0[2], m0[7:4]} : strap_cap)
      `CHK(spread, m0[1])
      `CHK({host_en, bus_en}, {m_host, m_pci})
   endtask

   task automatic wr_byte(input logic [6:0] idx, input logic [7:0] v);
      host.start();
      host.send8(SLAVE_ADDR, a0);
      host.send8({1'b1, idx}, a1);
      host.send8(v, a2);
      `CHK({a0, a1, a2}, 3'h0)
      model_wr(idx, v);
      host.stop();
   endtask

   task automatic rd_byte(input logic [6:0] idx);
      host.start();
      host.send8(SLAVE_ADDR, a0);
      host.send8({1'b1, idx}, a1);
      host.start();
      host.send8(SLAVE_ADDR | 8'h01, a2);
      host.recv8(d, 1'b1);
      host.stop();
      `CHK({a0, a1, a2}, 3'h0)
      `CHK(d, exp_rd(idx))
   endtask

   task automatic end_test(input string name);
      $display("test %s done, %0d mismatches so far", name, miscompares);
   endtask

   task automatic stop_test();
      $display("checked %0d, miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      stop_test();
   end

   initial begin
      i_reset = 1'b1;
      strap = 5'h00;
      miscompares = 0;
      checked = 0;
      void'($urandom(53));
      strap = 5'($urandom);
      strap_cap = strap;
      m0 = B0_RST;
      m_host = HOST_EN_RST;
      m_pci = PCI_EN_RST;
      repeat (3) @(negedge i_sys_clk);
      i_reset = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      strap = ~strap_cap; // Straps are latched once, later moves must not show
      chk_outs();
      for (int i = 0; i < 3; i++) begin
         rd_byte(7'(i));
      end
      end_test("reset");
      for (int i = 0; i < 12; i++) begin
         wr_byte(7'($urandom % 3), 8'($urandom));
         rd_byte(7'($urandom % 3));
         chk_outs();
      end
      wr_byte(IDX_FREQ, 8'hFF);
      chk_outs();
      wr_byte(IDX_FREQ, 8'hF7);
      chk_outs();
      end_test("random");
      wr_byte(7'h05, 8'hA5);
      rd_byte(7'h05);
      chk_outs();
      end_test("unmapped");
      host.start();
      host.send8(SLAVE_ADDR ^ 8'h04, a0);
      host.stop();
      `CHK(a0, 1'b1)
      end_test("address");
      host.start();
      host.send8(SLAVE_ADDR, a0);
      host.send8({1'b1, IDX_PCI}, a1);
      host.send8(8'h15, a2);
      host.send8(8'h3C, a3);
      host.stop();
      model_wr(IDX_PCI, 8'h15);
      `CHK({a0, a1, a2, a3}, 4'h1)
      chk_outs();
      end_test("extra_byte");
      host.start();
      host.send8(SLAVE_ADDR, a0);
      host.send8(8'h00, a1);
      host.send8(NUM_BYTES, a2);
      for (int i = 0; i < 3; i++) begin
         d = 8'($urandom);
         host.send8(d, a3);
         model_wr(7'(i), d);
         `CHK(a3, 1'b0)
      end
      `CHK({a0, a1, a2}, 3'h0)
      host.stop();
      chk_outs();
      host.start();
      host.send8(SLAVE_ADDR, a0);
      host.send8(8'h00, a1);
      host.start();
      host.send8(SLAVE_ADDR | 8'h01, a2);
      host.recv8(cnt, 1'b0);
      `CHK(cnt, NUM_BYTES)
      `CHK({a0, a1, a2}, 3'h0)
      for (int i = 0; i < 3; i++) begin
         host.recv8(d, i == 2);
         `CHK(d, exp_rd(7'(i)))
      end
      host.stop();
      end_test("block");
      stop_test();
   end
endmodule
